// ### hw/wdrt_pkg.sv
package wdrt_pkg;

    // counter geometry
    localparam int unsigned CNT_W              = 24;
    localparam logic [23:0] CNT_ZERO           = 24'h00_0000;
    localparam logic [23:0] CNT_MAX            = 24'hff_ffff;
    localparam logic [23:0] RELOAD_RST         = 24'h00_ffff;

    // register byte offsets on the avalon slave (word aligned)
    localparam logic [3:0]  OFS_CTRL           = 4'h0;
    localparam logic [3:0]  OFS_RELOAD         = 4'h4;
    localparam logic [3:0]  OFS_STATUS         = 4'h8;
    localparam logic [3:0]  OFS_MASK           = 4'hc;

    // control register fields
    localparam int unsigned CTRL_EN_BIT        = 0;
    localparam int unsigned CTRL_REFRESH_BIT   = 1;

    // status / mask fields
    localparam int unsigned ST_TIMEOUT_BIT     = 0;
    localparam int unsigned ST_STOP_BIT        = 1;
    localparam int unsigned ST_W               = 2;

    // reset values
    localparam logic [1:0]  MASK_RST           = 2'h0;
    localparam logic [31:0] UNMAPPED_RDATA     = 32'h0000_0000;

    typedef enum logic [1:0] {
        WDRT_IDLE,
        WDRT_LOAD,
        WDRT_COUNT
    } wdrt_state_e;

endpackage

// ### hw/wdrt_sync.sv
`timescale 1ns/10ps
`default_nettype none

// three-stage synchroniser; a change counts once stages two and three agree
module wdrt_sync
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic d_in,
    output logic      q_out
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic q_ff;

    // s1 feeds only s2, so no logic ever sees a metastable level
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            q_ff  <= 1'b0;
        end
        else
        begin
            s1_ff <= d_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff)
            begin
                q_ff <= s3_ff;
            end
        end
    end

    assign q_out = q_ff;

endmodule

`default_nettype wire

// ### hw/wdrt_top.sv
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - on first enable, load counter from reload register before counting.
// - counter decrements toward zero every cycle unless refreshed.
// - refresh instruction reloads counter from reload value, then counting resumes.
// - while debug unit holds debug mode, counter is refreshed every cycle.
// - time-out is recognised when the counter reaches zero.
// - option bit selects interrupt or system reset as time-out response.
// - interrupt response sets time-out flag and requests an interrupt.
// - after interrupt time-out counter wraps to all ones, no reload.
// - reading the status register clears the time-out flag.
// - interrupt-response time-out in stop mode starts stop recovery and requests an interrupt.
// - interrupt-response time-out in stop mode sets both time-out and stop flags.
module wdrt_top
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // core side
    input  wire logic        watchdog_refresh_instruction,
    input  wire logic        timeout_response_select,
    input  wire logic        debug_unit_active,
    input  wire logic        stop_mode,
    // results
    output logic             wdt_irq_req,
    output logic             irq,
    output logic             system_reset_req,
    output logic             stop_recovery_req,
    output logic [23:0]      count_value
);
    import wdrt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // signals

    logic              stop_sync;
    logic              debug_sync;
    logic              en_ff;
    logic [CNT_W-1:0]  reload_ff;
    logic [CNT_W-1:0]  cnt_ff;
    logic [CNT_W-1:0]  nxt_cnt;
    logic [ST_W-1:0]   status_ff;
    logic [ST_W-1:0]   mask_ff;
    logic [31:0]       rdata_ff;
    logic              ack_ff;
    logic              sw_refresh_ff;
    wdrt_state_e       state_ff;
    logic              timeout;
    logic              refresh;
    logic              wr_go;
    logic              rd_go;
    logic              irq_ff;
    logic              rst_req_ff;
    logic              stop_rec_ff;

    ////////////////////////////////////////////////////////////////////////////
    // pin inputs from other domains

    // stop and debug come from pins of the power / debug logic
    wdrt_sync u_sync_stop
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d_in    (stop_mode),
        .q_out   (stop_sync)
    );

    wdrt_sync u_sync_dbg
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d_in    (debug_unit_active),
        .q_out   (debug_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait state, answer on the second cycle of a request

    assign wr_go           = avs_write && ack_ff;
    assign rd_go           = avs_read && ack_ff;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    assign avs_readdata    = rdata_ff;

    // ack toggles so that a held request completes exactly once
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ack_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= (avs_read || avs_write) && !ack_ff;
        end
    end

    // read data is captured in the wait cycle so it stands at the ack edge
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rdata_ff <= UNMAPPED_RDATA;
        end
        else if (avs_read && !ack_ff)
        begin
            unique case (avs_address)
                OFS_CTRL:   rdata_ff <= {30'h000_0000, 1'b0, en_ff};
                OFS_RELOAD: rdata_ff <= {8'h00, reload_ff};
                OFS_STATUS: rdata_ff <= {30'h000_0000, status_ff};
                OFS_MASK:   rdata_ff <= {30'h000_0000, mask_ff};
                default:    rdata_ff <= UNMAPPED_RDATA;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    // enable bit only rises by software; reset is the only way back down
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            en_ff         <= 1'b0;
            reload_ff     <= RELOAD_RST;
            mask_ff       <= MASK_RST;
            sw_refresh_ff <= 1'b0;
        end
        else
        begin
            sw_refresh_ff <= 1'b0;
            if (wr_go && avs_address == OFS_CTRL && avs_byteenable[0])
            begin
                en_ff         <= en_ff | avs_writedata[CTRL_EN_BIT];
                sw_refresh_ff <= avs_writedata[CTRL_REFRESH_BIT];
            end
            if (wr_go && avs_address == OFS_RELOAD)
            begin
                if (avs_byteenable[0]) reload_ff[7:0]   <= avs_writedata[7:0];
                if (avs_byteenable[1]) reload_ff[15:8]  <= avs_writedata[15:8];
                if (avs_byteenable[2]) reload_ff[23:16] <= avs_writedata[23:16];
            end
            if (wr_go && avs_address == OFS_MASK && avs_byteenable[0])
            begin
                mask_ff <= avs_writedata[ST_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter

    assign refresh = watchdog_refresh_instruction || sw_refresh_ff || debug_sync;
    assign timeout = (state_ff == WDRT_COUNT) && (cnt_ff == CNT_ZERO) && !refresh;

    // state: idle until enabled, one load cycle, then counting
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_ff <= WDRT_IDLE;
        end
        else
        begin
            unique case (state_ff)
                WDRT_IDLE:  if (en_ff) state_ff <= WDRT_LOAD;
                WDRT_LOAD:  state_ff <= WDRT_COUNT;
                WDRT_COUNT: state_ff <= WDRT_COUNT;
            endcase
        end
    end

    always_comb
    begin
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            WDRT_IDLE:  nxt_cnt = cnt_ff;
            WDRT_LOAD:  nxt_cnt = reload_ff;
            WDRT_COUNT:
            begin
                if (refresh)
                    nxt_cnt = reload_ff;
                else if (cnt_ff == CNT_ZERO)
                    nxt_cnt = CNT_MAX;
                else
                    nxt_cnt = cnt_ff - 24'h00_0001;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            cnt_ff <= CNT_ZERO;
        else
            cnt_ff <= nxt_cnt;
    end

    assign count_value = cnt_ff;

    ////////////////////////////////////////////////////////////////////////////
    // status flags: set wins over the clear-on-read

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            status_ff <= '0;
        end
        else
        begin
            // clear only what the read reported, so a time-out that lands between
            // the capture and the completing edge is not lost
            if (rd_go && avs_address == OFS_STATUS)
                status_ff <= status_ff & ~rdata_ff[ST_W-1:0];
            if (timeout && !timeout_response_select)
            begin
                status_ff[ST_TIMEOUT_BIT] <= 1'b1;
                if (stop_sync)
                    status_ff[ST_STOP_BIT] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // time-out responses, registered one cycle after the zero

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rst_req_ff  <= 1'b0;
            stop_rec_ff <= 1'b0;
            irq_ff      <= 1'b0;
        end
        else
        begin
            rst_req_ff  <= timeout && timeout_response_select;
            stop_rec_ff <= timeout && !timeout_response_select && stop_sync;
            irq_ff      <= |(nxt_status() & mask_ff);
        end
    end

    // status value as it will stand after this edge, so irq tracks the flags
    function automatic logic [ST_W-1:0] nxt_status();
        logic [ST_W-1:0] s;
        s = status_ff;
        if (rd_go && avs_address == OFS_STATUS)
            s = s & ~rdata_ff[ST_W-1:0];
        if (timeout && !timeout_response_select)
        begin
            s[ST_TIMEOUT_BIT] = 1'b1;
            if (stop_sync)
                s[ST_STOP_BIT] = 1'b1;
        end
        return s;
    endfunction

    // level request to the interrupt controller while the time-out flag stands;
    // the core defers servicing until stop recovery is done
    assign wdt_irq_req       = status_ff[ST_TIMEOUT_BIT];
    assign irq               = irq_ff;
    assign system_reset_req  = rst_req_ff;
    assign stop_recovery_req = stop_rec_ff;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    a_first_load: assert property (@(posedge clk_sys) disable iff (rst)
        state_ff == WDRT_LOAD |=> cnt_ff == $past(reload_ff))
        else $error("counter not loaded on enable");

    a_count_down: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == WDRT_COUNT && !refresh && cnt_ff != CNT_ZERO)
        |=> cnt_ff == $past(cnt_ff) - 24'h00_0001)
        else $error("counter did not decrement");

    a_refresh_load: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == WDRT_COUNT && watchdog_refresh_instruction)
        |=> cnt_ff == $past(reload_ff))
        else $error("refresh did not reload");

    a_debug_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == WDRT_COUNT && debug_sync) |=> cnt_ff == $past(reload_ff))
        else $error("debug mode did not refresh");

    a_reset_resp: assert property (@(posedge clk_sys) disable iff (rst)
        (timeout && timeout_response_select) |=> system_reset_req && !$rose(wdt_irq_req))
        else $error("reset response missing");

    a_irq_flag: assert property (@(posedge clk_sys) disable iff (rst)
        (timeout && !timeout_response_select) |=> wdt_irq_req)
        else $error("time-out flag not set");

    a_wrap_max: assert property (@(posedge clk_sys) disable iff (rst)
        timeout |=> cnt_ff == CNT_MAX)
        else $error("counter did not wrap");

    a_read_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (rd_go && avs_address == OFS_STATUS && !timeout)
        |=> status_ff == ($past(status_ff) & ~$past(rdata_ff[ST_W-1:0])))
        else $error("status not cleared on read");

    sequence s_stop_timeout;
        timeout && !timeout_response_select && stop_sync;
    endsequence

    a_stop_recov: assert property (@(posedge clk_sys) disable iff (rst)
        s_stop_timeout |=> stop_recovery_req ##0 wdt_irq_req)
        else $error("stop recovery not started");

    a_stop_flags: assert property (@(posedge clk_sys) disable iff (rst)
        s_stop_timeout |=> status_ff == 2'h3)
        else $error("stop flags not set");

endmodule

`default_nettype wire

// ### tb/wdrt_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// stand-in for the core and its wake-up logic on the far side of the watchdog
module wdrt_core_model
#(
    parameter int RECOV_CYC = 6
)
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic refresh_cmd,
    input  wire logic stop_recovery_req,
    output logic      refresh_instr,
    output logic      core_awake
);
    int rec_cnt_ff;

    // one refresh instruction per request, a cycle late like a fetched opcode
    always_ff @(posedge clk_sys)
        refresh_instr <= !rst && refresh_cmd;

    // handler may run only once recovery is over, so awake lags the request
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rec_cnt_ff <= 0;
            core_awake <= 1'b0;
        end
        else if (stop_recovery_req)
        begin
            rec_cnt_ff <= RECOV_CYC;
            core_awake <= 1'b0;
        end
        else if (rec_cnt_ff > 0)
        begin
            rec_cnt_ff <= rec_cnt_ff - 1;
            core_awake <= (rec_cnt_ff == 1);
        end
    end
endmodule

`default_nettype wire

// ### tb/wdrt_top_tb.sv
`timescale 1ns/10ps
`default_nettype none

module wdrt_top_tb;
    import wdrt_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        refresh_cmd = 1'b0;
    logic        refresh_instr;
    logic        resp_sel = 1'b0;
    logic        dbg_on = 1'b0;
    logic        stop_mode = 1'b0;
    logic        wdt_irq_req;
    logic        irq;
    logic        system_reset_req;
    logic        stop_recovery_req;
    logic        core_awake;
    logic [23:0] count_value;
    logic [23:0] rl;
    logic [31:0] exp_q[$];
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          seed = 76537;

    always #2 clk_sys = ~clk_sys;

    wdrt_top uut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .watchdog_refresh_instruction(refresh_instr),
        .timeout_response_select(resp_sel), .debug_unit_active(dbg_on),
        .stop_mode(stop_mode), .wdt_irq_req(wdt_irq_req), .irq(irq),
        .system_reset_req(system_reset_req), .stop_recovery_req(stop_recovery_req),
        .count_value(count_value));

    wdrt_core_model core (.clk_sys(clk_sys), .rst(rst), .refresh_cmd(refresh_cmd),
        .stop_recovery_req(stop_recovery_req), .refresh_instr(refresh_instr),
        .core_awake(core_awake));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", what, e, g);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
            @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wait_cnt(input logic [23:0] v, input int lim);
        int n;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while (count_value !== v && n < lim);
        chk("count_value", {8'h00, v}, {8'h00, count_value});
    endtask

    // k picks the awaited flag; all are sampled mid-cycle so pulses are not missed
    task automatic wait_for(input int k, input int lim);
        int   n;
        logic f;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
            f = (k == 0) ? stop_recovery_req : (k == 1) ? system_reset_req
                : (k == 2) ? irq : core_awake;
        end
        while (n < lim && f !== 1'b1);
        // a limit that runs out counts as a mismatch here
        chk("awaited flag", 32'h0000_0001, {31'h0, f});
    endtask

    task automatic refresh();
        @(posedge clk_sys);
        refresh_cmd <= 1'b1;
        @(posedge clk_sys);
        refresh_cmd <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // read checker: data taken at the rising edge that completes the read
    always @(posedge clk_sys)
        if (avs_read && avs_waitrequest === 1'b0)
            chk("readdata", exp_q.pop_front(), avs_readdata);

    // hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #80000;
        n_mismatch++;
        test_done();
    end

    initial
    begin
        rl = 24'({$random(seed)} % 24 + 8);
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rd(OFS_RELOAD, {8'h00, RELOAD_RST});
        rd(OFS_MASK, 32'h0000_0000);
        bus(1'b1, 4'h2, 32'hffff_ffff);
        rd(4'h2, UNMAPPED_RDATA);
        chk("count_value", 32'h0000_0000, {8'h00, count_value});
        $display("test reset done");
        bus(1'b1, OFS_RELOAD, {8'h00, rl});
        bus(1'b1, OFS_CTRL, 32'h0000_0001);
        wait_cnt(rl, 4);
        wait_cnt(rl - 24'h1, 1);
        wait_cnt(rl - 24'h4, 8);
        refresh();
        wait_cnt(rl, 4);
        wait_cnt(rl - 24'h1, 1);
        bus(1'b1, OFS_CTRL, 32'h0000_0003);
        wait_cnt(rl, 4);
        $display("test load and refresh done");
        wait_cnt(CNT_ZERO, 40);
        wait_cnt(CNT_MAX, 1);
        wait_cnt(CNT_MAX - 24'h1, 1);
        chk("wdt_irq_req", 32'h1, {31'h0, wdt_irq_req});
        chk("irq", 32'h0, {31'h0, irq});
        rd(OFS_STATUS, 32'h0000_0001);
        rd(OFS_STATUS, 32'h0000_0000);
        chk("wdt_irq_req", 32'h0, {31'h0, wdt_irq_req});
        bus(1'b1, OFS_CTRL, 32'h0000_0000);
        rd(OFS_CTRL, 32'h0000_0001);
        bus(1'b1, OFS_MASK, 32'h0000_0003);
        refresh();
        wait_for(2, 60);
        chk("irq", 32'h1, {31'h0, irq});
        rd(OFS_STATUS, 32'h0000_0001);
        repeat (2) @(negedge clk_sys);
        chk("irq", 32'h0, {31'h0, irq});
        $display("test interrupt response done");
        @(posedge clk_sys) stop_mode <= 1'b1;
        refresh();
        wait_for(0, 60);
        chk("stop_recovery_req", 32'h1, {31'h0, stop_recovery_req});
        wait_for(3, 20);
        rd(OFS_STATUS, 32'h0000_0003);
        stop_mode <= 1'b0;
        $display("test stop mode done");
        resp_sel <= 1'b1;
        refresh();
        wait_for(1, 60);
        chk("system_reset_req", 32'h1, {31'h0, system_reset_req});
        rd(OFS_STATUS, 32'h0000_0000);
        resp_sel <= 1'b0;
        $display("test reset response done");
        refresh();
        dbg_on <= 1'b1;
        repeat (3 * rl + 20) @(negedge clk_sys);
        chk("count_value", {8'h00, rl}, {8'h00, count_value});
        chk("wdt_irq_req", 32'h0, {31'h0, wdt_irq_req});
        $display("test debug refresh done");
        test_done();
    end
endmodule

`default_nettype wire
